// ### charge_time_unit_defs.svh
`ifndef CHARGE_TIME_UNIT_DEFS_SVH
`define CHARGE_TIME_UNIT_DEFS_SVH
// Register byte addresses
`define CTU_ADDR_CTRL_HIGH 4'h0
`define CTU_ADDR_EDGE_SEL 4'h4
`define CTU_ADDR_TRIM_RANGE 4'h8
`define CTU_ADDR_STATUS 4'hc
// Reset values
`define CTU_RESET_VALUE 8'h00
// Control high fields
`define CTU_BIT_ENABLE 7
`define CTU_BIT_UNUSED 6
`define CTU_BIT_STOP_IDLE 5
`define CTU_BIT_PULSE_GEN 4
`define CTU_BIT_EDGE_GATE 3
`define CTU_BIT_EDGE_ORDER 2
`define CTU_BIT_GROUND 1
`define CTU_BIT_ADC_TRIG 0
`define CTU_CTRL_HIGH_MASK 8'hbf
// Edge select fields
`define CTU_BIT_STOP_POL 7
`define CTU_BIT_START_POL 4
`define CTU_BIT_STOP_SEEN 1
`define CTU_BIT_START_SEEN 0
// Edge source codes
`define CTU_SRC_PIN_A 2'h3
`define CTU_SRC_PIN_B 2'h2
`define CTU_SRC_CMP_A 2'h1
`define CTU_SRC_CMP_B 2'h0
// Range codes
`define CTU_RANGE_OFF 2'h0
`endif

// ### charge_time_unit_pkg.sv
package charge_time_unit_pkg;
  typedef struct packed {
    logic pin_a;
    logic pin_b;
    logic cmp_a;
    logic cmp_b;
  } edge_src_type;
  typedef struct packed {
    logic source_on;
    logic source_ground;
    logic [5:0] trim;
    logic [1:0] range;
  } analog_ctrl_type;
endpackage : charge_time_unit_pkg

// ### charge_time_unit.sv
`timescale 1ns/10ps
`include "charge_time_unit_defs.svh"
// Function
// - Peripheral disable stops all unit activity
// - Any reset clears every register
// - Reset discards measurement; software reconfigures
// - Bit 7 enables the whole unit
// - Stop-in-idle halts unit during idle
// - Bit 4 enables delay pulse generation
// - Edge gate passes or blocks edges
// - Ordered mode needs start before stop
// - Bit 1 grounds current source output
// - Bit 0 enables converter trigger
// - Stop polarity selects rising or falling
// - Stop source selects pin or compare
// - Start polarity selects rising or falling
// - Start source uses same encoding
// - Status bits set on edges, writable
// - Six-bit signed current trim field
// - Range field selects current, 00 off
// - Control bit 6 reads zero always
// - Sleep forces current source off
// - Pulse out at comparator trip
module charge_time_unit
  import charge_time_unit_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Device power state
  input wire logic unit_power_off_i,
  input wire logic idle_mode_i,
  input wire logic sleep_mode_i,
  // Edge sources and comparator
  input wire edge_src_type edge_src_i,
  input wire logic comparator_trip_i,
  // Analog and converter side
  output analog_ctrl_type analog_o,
  output logic adc_trigger_o,
  output logic delay_pulse_out_o
);

  logic [7:0] ctrl_high_r;
  logic [7:0] edge_sel_r;
  logic [7:0] trim_range_r;
  logic [31:0] wb_dat_r;
  logic wb_ack_r;
  edge_src_type src_meta_r;
  edge_src_type src_sync_r;
  edge_src_type src_prev_r;
  logic trip_meta_r;
  logic trip_sync_r;
  logic trip_prev_r;
  logic power_meta_r;
  logic power_sync_r;
  logic idle_meta_r;
  logic idle_sync_r;
  logic sleep_meta_r;
  logic sleep_sync_r;
  analog_ctrl_type analog_r;
  logic adc_trigger_r;
  logic pulse_r;

  logic active;
  logic start_hit;
  logic stop_hit;
  logic stop_seen_nxt;
  logic start_seen_nxt;
  logic wr_edge_sel;
  logic bus_req;

  // Picks the selected source and detects the programmed edge
  function automatic logic edge_hit(input edge_src_type cur, input edge_src_type prev,
                                    input logic [1:0] sel, input logic rising);
    logic c;
    logic p;
    c = 1'b0;
    p = 1'b0;
    case (sel)
      `CTU_SRC_PIN_A: begin
        c = cur.pin_a;
        p = prev.pin_a;
      end
      `CTU_SRC_PIN_B: begin
        c = cur.pin_b;
        p = prev.pin_b;
      end
      `CTU_SRC_CMP_A: begin
        c = cur.cmp_a;
        p = prev.cmp_a;
      end
      default: begin
        c = cur.cmp_b;
        p = prev.cmp_b;
      end
    endcase
    return rising ? (c & ~p) : (~c & p);
  endfunction : edge_hit

  // Edge pins are asynchronous, so every outside level is synchronised first
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      src_meta_r <= '0;
      src_sync_r <= '0;
      src_prev_r <= '0;
      trip_meta_r <= 1'b0;
      trip_sync_r <= 1'b0;
      trip_prev_r <= 1'b0;
      power_meta_r <= 1'b0;
      power_sync_r <= 1'b0;
      idle_meta_r <= 1'b0;
      idle_sync_r <= 1'b0;
      sleep_meta_r <= 1'b0;
      sleep_sync_r <= 1'b0;
    end else begin
      src_meta_r <= edge_src_i;
      src_sync_r <= src_meta_r;
      src_prev_r <= src_sync_r;
      trip_meta_r <= comparator_trip_i;
      trip_sync_r <= trip_meta_r;
      trip_prev_r <= trip_sync_r;
      power_meta_r <= unit_power_off_i;
      power_sync_r <= power_meta_r;
      idle_meta_r <= idle_mode_i;
      idle_sync_r <= idle_meta_r;
      sleep_meta_r <= sleep_mode_i;
      sleep_sync_r <= sleep_meta_r;
    end
  end

  // Gated clocks are avoided; the disable drops the active qualifier instead, and bus registers stay writable
  assign active = ctrl_high_r[`CTU_BIT_ENABLE] & ~power_sync_r
                  & ~(idle_sync_r & ctrl_high_r[`CTU_BIT_STOP_IDLE]);

  assign start_hit = active & ctrl_high_r[`CTU_BIT_EDGE_GATE]
                     & edge_hit(src_sync_r, src_prev_r, edge_sel_r[3:2],
                                edge_sel_r[`CTU_BIT_START_POL]);
  assign stop_hit = active & ctrl_high_r[`CTU_BIT_EDGE_GATE]
                    & edge_hit(src_sync_r, src_prev_r, edge_sel_r[6:5],
                               edge_sel_r[`CTU_BIT_STOP_POL])
                    & (~ctrl_high_r[`CTU_BIT_EDGE_ORDER]
                       | edge_sel_r[`CTU_BIT_START_SEEN]);

  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_r;
  assign wr_edge_sel = bus_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `CTU_ADDR_EDGE_SEL);

  // Hardware set wins over a software write in the same cycle
  always_comb begin
    start_seen_nxt = edge_sel_r[`CTU_BIT_START_SEEN];
    stop_seen_nxt = edge_sel_r[`CTU_BIT_STOP_SEEN];
    if (wr_edge_sel) begin
      start_seen_nxt = wb_dat_i[`CTU_BIT_START_SEEN];
      stop_seen_nxt = wb_dat_i[`CTU_BIT_STOP_SEEN];
    end
    if (start_hit) begin
      start_seen_nxt = 1'b1;
    end
    if (stop_hit) begin
      stop_seen_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_high_r <= `CTU_RESET_VALUE;
      trim_range_r <= `CTU_RESET_VALUE;
    end else if (bus_req && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == `CTU_ADDR_CTRL_HIGH) begin
        ctrl_high_r <= wb_dat_i[7:0] & `CTU_CTRL_HIGH_MASK;
      end
      if (wb_adr_i == `CTU_ADDR_TRIM_RANGE) begin
        trim_range_r <= wb_dat_i[7:0];
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      edge_sel_r <= `CTU_RESET_VALUE;
    end else begin
      if (wr_edge_sel) begin
        edge_sel_r[7:2] <= wb_dat_i[7:2];
      end
      edge_sel_r[`CTU_BIT_STOP_SEEN] <= stop_seen_nxt;
      edge_sel_r[`CTU_BIT_START_SEEN] <= start_seen_nxt;
    end
  end

  // Single-cycle classic answer: ack one edge after the request
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wb_ack_r <= 1'b0;
      wb_dat_r <= '0;
    end else begin
      wb_ack_r <= bus_req;
      wb_dat_r <= '0;
      if (bus_req && !wb_we_i) begin
        case (wb_adr_i)
          `CTU_ADDR_CTRL_HIGH: wb_dat_r <= {24'h000000, ctrl_high_r};
          `CTU_ADDR_EDGE_SEL: wb_dat_r <= {24'h000000, edge_sel_r};
          `CTU_ADDR_TRIM_RANGE: wb_dat_r <= {24'h000000, trim_range_r};
          `CTU_ADDR_STATUS: wb_dat_r <= {29'h0, sleep_sync_r, idle_sync_r, active};
          default: wb_dat_r <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      analog_r <= '0;
    end else begin
      analog_r.source_on <= active & ~sleep_sync_r
                            & (trim_range_r[1:0] != `CTU_RANGE_OFF)
                            & (edge_sel_r[`CTU_BIT_START_SEEN]
                               ^ edge_sel_r[`CTU_BIT_STOP_SEEN]);
      analog_r.source_ground <= ctrl_high_r[`CTU_BIT_GROUND];
      analog_r.trim <= trim_range_r[7:2];
      analog_r.range <= trim_range_r[1:0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      adc_trigger_r <= 1'b0;
      pulse_r <= 1'b0;
    end else begin
      adc_trigger_r <= stop_hit & ctrl_high_r[`CTU_BIT_ADC_TRIG]
                       & ~edge_sel_r[`CTU_BIT_STOP_SEEN];
      pulse_r <= active & ctrl_high_r[`CTU_BIT_PULSE_GEN]
                 & trip_sync_r & ~trip_prev_r;
    end
  end

  assign wb_ack_o = wb_ack_r;
  assign wb_dat_o = wb_dat_r;
  assign analog_o = analog_r;
  assign adc_trigger_o = adc_trigger_r;
  assign delay_pulse_out_o = pulse_r;

  bit6_zero_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    !ctrl_high_r[`CTU_BIT_UNUSED]) else $error("control bit 6 set");
  power_off_freeze_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    power_sync_r |-> ##1 !adc_trigger_o && !delay_pulse_out_o) else $error("active while off");
  gate_blocks_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    !ctrl_high_r[`CTU_BIT_EDGE_GATE] && !wr_edge_sel
    |=> edge_sel_r[1:0] == $past(edge_sel_r[1:0])) else $error("edge passed gate");
  order_hold_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    ctrl_high_r[`CTU_BIT_EDGE_ORDER] && !edge_sel_r[0] && !start_hit && !wr_edge_sel
    && !edge_sel_r[1] |=> !edge_sel_r[1]) else $error("stop before start");
  start_set_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    start_hit |=> edge_sel_r[0]) else $error("start edge lost");
  sleep_off_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    sleep_sync_r |=> !analog_o.source_on) else $error("source on in sleep");
  ground_follow_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    ##1 analog_o.source_ground == $past(ctrl_high_r[1])) else $error("ground mismatch");
  trig_one_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    adc_trigger_o |=> !adc_trigger_o) else $error("trigger too long");
  trig_gate_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    adc_trigger_o |-> $past(ctrl_high_r[0]) && edge_sel_r[1]) else $error("stray trigger");
  pulse_gen_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    delay_pulse_out_o |-> $past(ctrl_high_r[4])) else $error("pulse without enable");
  charge_xor_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    analog_o.source_on |-> $past(edge_sel_r[0] ^ edge_sel_r[1])) else $error("bad charge");
  stop_set_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    stop_hit |=> edge_sel_r[`CTU_BIT_STOP_SEEN]) else $error("stop edge lost");
  enable_off_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    !ctrl_high_r[`CTU_BIT_ENABLE] |=> !adc_trigger_o && !delay_pulse_out_o)
    else $error("active while disabled");
  idle_stop_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    idle_sync_r && ctrl_high_r[`CTU_BIT_STOP_IDLE] |=> !analog_o.source_on && !adc_trigger_o)
    else $error("active in idle");
  range_off_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    analog_o.range == `CTU_RANGE_OFF |-> !analog_o.source_on) else $error("source on, range off");
  trim_follow_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    ##1 analog_o.trim == $past(trim_range_r[7:2])) else $error("trim mismatch");
  trig_stop_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
    adc_trigger_o |-> $past(stop_hit)) else $error("trigger without stop edge");

endmodule : charge_time_unit

// ### edge_source_model.sv
`timescale 1ns/10ps
module edge_source_model
  import charge_time_unit_pkg::*;
(
  // Clock
  input wire logic sys_clk_i,
  // Sources, comparator and converter
  output edge_src_type edge_src_o,
  output logic trip_o,
  input wire logic adc_trigger_i
);
  logic [4:0] lv = 5'h00;
  int trig_count = 0;
  assign edge_src_o = lv[3:0];
  assign trip_o = lv[4];
  // Converter counts each single-cycle trigger it is handed
  always @(posedge sys_clk_i) begin
    if (adc_trigger_i === 1'b1) trig_count++;
  end
  // Pins and compare outputs are levels; an edge is one change of lv
  task automatic drive(input int idx, input logic val);
    logic [4:0] v;
    v = lv;
    v[idx] = val;
    lv <= v;
  endtask : drive
  task automatic idle_all();
    lv <= 5'h00;
  endtask : idle_all
endmodule : edge_source_model

// ### tb_charge_time_unit.sv
`timescale 1ns/10ps
module tb_charge_time_unit;
  import charge_time_unit_pkg::*;
  typedef struct packed {logic [3:0] a; logic [7:0] w; logic [7:0] e;} row_type;
  logic sys_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] dat_o;
  logic [31:0] rdat;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic pwr_off = 1'b0;
  logic idle = 1'b0;
  logic sleep = 1'b0;
  logic ack;
  logic trig;
  logic pulse;
  logic trip;
  edge_src_type src;
  analog_ctrl_type ana;
  int num_errors = 0;
  int n_tests = 0;
  row_type rows [6] = '{
    '{4'h0, 8'hff, 8'hbf},
    '{4'h0, 8'h7f, 8'h3f},
    '{4'h4, 8'hec, 8'hec},
    '{4'h8, 8'h86, 8'h86},
    '{4'hd, 8'hff, 8'h00},
    '{4'h8, 8'h7d, 8'h7d}
  };
  logic [9:0] blk [3] = '{
    {8'h80, 2'b00},
    {8'ha8, 2'b01},
    {8'h88, 2'b10}
  };
  logic [1:0] st [3] = '{2'b01, 2'b10, 2'b00};
  always #12.5 sys_clk_i = ~sys_clk_i;
  charge_time_unit charge_time_unit_inst (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .unit_power_off_i(pwr_off), .idle_mode_i(idle),
    .sleep_mode_i(sleep), .edge_src_i(src), .comparator_trip_i(trip),
    .analog_o(ana), .adc_trigger_o(trig), .delay_pulse_out_o(pulse)
  );
  edge_source_model edge_source_model_inst (
    .sys_clk_i(sys_clk_i), .edge_src_o(src), .trip_o(trip), .adc_trigger_i(trig)
  );
  task automatic tally_and_finish();
    $display("comparisons %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : check
  // Request held until ack is sampled high; one idle cycle follows
  task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d);
    int k;
    {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'h1, 24'h0, d};
    k = 0;
    do begin
      @(posedge sys_clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (k >= 20) begin
      num_errors++;
      tally_and_finish();
    end
    rdat = dat_o;
    {cyc, stb} <= 2'b00;
    @(posedge sys_clk_i);
  endtask : xfer
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    check({24'h0, e}, rdat);
  endtask : rd_chk
  // Waits for source_on (0), trigger (1) or pulse (2); a hang ends the run
  task automatic await(input int s);
    int k;
    logic [2:0] v;
    k = 0;
    do begin
      @(posedge sys_clk_i);
      v = {pulse, trig, ana.source_on};
      k++;
    end while (v[s] !== 1'b1 && k < 20);
    check(32'h1, {31'h0, v[s]});
    if (k >= 20) tally_and_finish();
  endtask : await
  initial begin
    logic [1:0] p;
    repeat (16) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    @(posedge sys_clk_i);
    check(32'h0, {22'h0, ana});
    for (int i = 0; i < 12; i += 4) rd_chk(4'(i), 8'h00);
    foreach (rows[i]) begin
      xfer(1'b1, rows[i].a, rows[i].w);
      rd_chk(rows[i].a, rows[i].e);
    end
    check(32'h7d, {24'h0, ana.trim, ana.range});
    xfer(1'b1, 4'h0, 8'h82);
    check(32'h1, {31'h0, ana.source_ground});
    xfer(1'b1, 4'h0, 8'h80);
    check(32'h0, {31'h0, ana.source_ground});
    xfer(1'b1, 4'h8, 8'h01);
    for (int i = 0; i < 4; i++) begin
      p = 2'(i + 1);
      xfer(1'b1, 4'h4, {1'b1, p, 1'b1, 2'(i), 2'b00});
      xfer(1'b1, 4'h0, 8'h89);
      edge_source_model_inst.drive(i, 1'b1);
      await(0);
      rd_chk(4'h4, {1'b1, p, 1'b1, 2'(i), 2'b01});
      edge_source_model_inst.drive(int'(p), 1'b1);
      await(1);
      @(posedge sys_clk_i);
      check(32'h0, {31'h0, trig});
      check(32'(i + 1), 32'(edge_source_model_inst.trig_count));
      repeat (2) @(posedge sys_clk_i);
      check(32'h0, {31'h0, ana.source_on});
      edge_source_model_inst.idle_all();
      // Rising polarity, so the falling lines cannot raise a stray trigger
      xfer(1'b1, 4'h4, 8'h90);
    end
    xfer(1'b1, 4'h0, 8'h8c);
    xfer(1'b1, 4'h4, 8'hf8);
    edge_source_model_inst.drive(3, 1'b1);
    repeat (6) @(posedge sys_clk_i);
    rd_chk(4'h4, 8'hf8);
    edge_source_model_inst.drive(2, 1'b1);
    repeat (6) @(posedge sys_clk_i);
    rd_chk(4'h4, 8'hf9);
    xfer(1'b1, 4'h4, 8'h0c);
    edge_source_model_inst.drive(3, 1'b0);
    repeat (6) @(posedge sys_clk_i);
    rd_chk(4'h4, 8'h0d);
    edge_source_model_inst.idle_all();
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, 4'h0, blk[i][9:2]);
      {pwr_off, idle} <= blk[i][1:0];
      xfer(1'b1, 4'h4, 8'h18);
      edge_source_model_inst.drive(2, 1'b1);
      repeat (6) @(posedge sys_clk_i);
      edge_source_model_inst.idle_all();
      repeat (6) @(posedge sys_clk_i);
      rd_chk(4'hc, {6'h0, st[i]});
      {pwr_off, idle} <= 2'b00;
      rd_chk(4'h4, 8'h18);
    end
    xfer(1'b1, 4'h0, 8'h90);
    edge_source_model_inst.drive(4, 1'b1);
    await(2);
    edge_source_model_inst.idle_all();
    xfer(1'b1, 4'h4, 8'h01);
    xfer(1'b1, 4'h0, 8'h80);
    await(0);
    sleep <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    check(32'h0, {31'h0, ana.source_on});
    sleep <= 1'b0;
    resetn_i <= 1'b0;
    @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_chk(4'h4, 8'h00);
    check(32'h0, {22'h0, ana});
    tally_and_finish();
  end
endmodule : tb_charge_time_unit
